// ### verilog/port_phy_pkg.sv
package port_phy_pkg;

   // Register indices of the per-port bank; byte address is four times the index.
   localparam logic [7:0]  CTRL_IDX        = 8'h12;
   localparam logic [7:0]  STAT_IDX        = 8'h13;
   localparam logic [7:0]  EMASK_IDX       = 8'h14;
   localparam int          PORT_SEL_LSB    = 8;
   localparam logic [1:0]  PORT_AREA       = 2'h0;
   localparam logic [1:0]  GLOBAL_AREA     = 2'h1;

   // Global registers, byte offsets inside the global area.
   localparam logic [7:0]  IRQ_STATUS_OFS  = 8'h00;
   localparam logic [7:0]  IRQ_MASK_OFS    = 8'h04;
   localparam logic [7:0]  SUMMARY_OFS     = 8'h08;
   localparam logic [7:0]  MAU_FLAG_OFS    = 8'h0c;
   localparam logic [7:0]  SOFT_RESET_OFS  = 8'h10;

   // Control field positions.
   localparam int          CTRL_FORCE_LINK = 15;
   localparam int          CTRL_IRQ_PIN_EN = 5;
   localparam int          CTRL_NO_LINK_PULSE = 4;
   localparam int          CTRL_POL_FIX_OFF = 3;
   localparam int          CTRL_AUI_SEL    = 2;
   localparam int          CTRL_EXT_DIST   = 1;
   localparam int          CTRL_HB_OFF     = 0;
   localparam logic [15:0] CTRL_WMASK      = 16'h803f;
   localparam logic [15:0] CTRL_KEEP_SRST  = 16'h0024;
   localparam logic [15:0] CTRL_RESET      = 16'h0020;

   // Status and error-mask field positions.
   localparam int          ST_RATE         = 2;
   localparam int          ST_POL_REV      = 1;
   localparam int          ST_JABBER       = 0;
   localparam logic [15:0] EMASK_WMASK     = 16'h0007;
   localparam logic [15:0] EMASK_RESET     = 16'h0000;
   localparam int          MAU_FLAG_BIT    = 1;
   localparam int          SUMMARY_STRIDE  = 4;

   // Heartbeat timing.
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          HB_DELAY_NS     = 1000;
   localparam int          HB_WIDTH_NS     = 1000;
   localparam int          HB_DELAY_CYC    = HB_DELAY_NS / CLK_PERIOD_NS;
   localparam int          HB_WIDTH_CYC    = HB_WIDTH_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      HB_IDLE  = 3'b001,
      HB_WAIT  = 3'b010,
      HB_PULSE = 3'b100
   } hb_state_t;

endpackage : port_phy_pkg

// ### verilog/heartbeat_check.sv
`timescale 1ns/1ps
module heartbeat_check import port_phy_pkg::*; (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic tx_active,
   input  wire logic inhibit,
   output logic      collision
);

   localparam logic [7:0] DELAY_LAST = 8'(HB_DELAY_CYC - 1);
   localparam logic [7:0] WIDTH_LAST = 8'(HB_WIDTH_CYC - 1);

   hb_state_t  state;
   hb_state_t  next_state;
   logic [7:0] count;
   logic       tx_prev;
   wire        tx_end   = tx_prev & ~tx_active;
   wire        cnt_done = (state == HB_WAIT) ? (count == DELAY_LAST) : (count == WIDTH_LAST);

   // A new frame or an inhibit aborts the pending heartbeat at once.
   always_comb begin
      next_state = state;
      case (state)
         HB_IDLE:  next_state = (tx_end && !inhibit) ? HB_WAIT : HB_IDLE;
         HB_WAIT:  next_state = (inhibit || tx_active) ? HB_IDLE :
                                (cnt_done ? HB_PULSE : HB_WAIT);
         HB_PULSE: next_state = (inhibit || cnt_done) ? HB_IDLE : HB_PULSE;
         default:  next_state = HB_IDLE;
      endcase
   end

   // State, counter and the registered collision output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= HB_IDLE;
         count     <= 8'h00;
         tx_prev   <= 1'b0;
         collision <= 1'b0;
      end else begin
         state     <= next_state;
         count     <= (next_state != state) ? 8'h00 : count + 8'h01;
         tx_prev   <= tx_active;
         collision <= (next_state == HB_PULSE);
      end
   end

endmodule : heartbeat_check

// ### verilog/port_phy_control_status_regs.sv
`timescale 1ns/1ps
// Function
// - Force bit holds link state machine good
// - Reserved ranges read zero, read-only
// - Port-0 bit 5 enables interrupt pin
// - Bit 4 suppresses link pulses
// - Bit 3 disables polarity correction
// - Port-0 bit 2 selects attachment interface
// - Bit 1 selects extended distance squelch
// - Bit 0 disables heartbeat
// - Heartbeat 1 us after frame, 1 us
// - Full duplex always inhibits heartbeat
// - Rate mismatch sticky, cleared on read
// - Polarity reversed bit follows live state
// - Jabber bit follows live jabber state
// - Separate register set per port
// - Error mask gates summary contributions
// - Global MAU flag sets, clears on read
// - Summary holds one MAU bit per port
module port_phy_control_status_regs import port_phy_pkg::*; #(
   parameter int NPORT = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NPORT-1:0]  rate_mismatch_evt,
   input  wire logic [NPORT-1:0]  rx_polarity_reversed,
   input  wire logic [NPORT-1:0]  tx_jabber,
   input  wire logic [NPORT-1:0]  tx_active,
   input  wire logic [NPORT-1:0]  full_duplex,
   output logic      [NPORT-1:0]  force_link_good,
   output logic      [NPORT-1:0]  link_pulse_disable,
   output logic      [NPORT-1:0]  polarity_corr_disable,
   output logic      [NPORT-1:0]  extended_distance,
   output logic                   aui_select,
   output logic                   aui_special_mode,
   output logic      [NPORT-1:0]  muxed_collision_out,
   output logic      [NPORT-1:0]  mau_error_summary,
   output logic                   irq,
   output logic                   status_change_irq_n
);

   // The summary layout and the port field of the address fit four ports only.
   if (NPORT != 4) begin : g_bad_nport
      $error("port_phy_control_status_regs supports exactly four ports");
   end

   localparam int NIN = 5 * NPORT;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [NIN-1:0] in_s1;
   logic [NIN-1:0] in_s2;
   logic [NIN-1:0] in_s3;
   logic [NIN-1:0] in_f;
   wire  [NIN-1:0] in_raw = {full_duplex, tx_active, tx_jabber,
                             rx_polarity_reversed, rate_mismatch_evt};

   // Three stages; the filtered copy moves only when stages two and three agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_s1 <= '0;
         in_s2 <= '0;
         in_s3 <= '0;
         in_f  <= '0;
      end else begin
         in_s1 <= in_raw;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         in_f  <= (in_s2 & in_s3) | (in_f & (in_s2 ^ in_s3));
      end
   end

   wire [NPORT-1:0] rate_f   = in_f[NPORT-1:0];
   wire [NPORT-1:0] polrev_f = in_f[2*NPORT-1:NPORT];
   wire [NPORT-1:0] jabber_f = in_f[3*NPORT-1:2*NPORT];
   wire [NPORT-1:0] txact_f  = in_f[4*NPORT-1:3*NPORT];
   wire [NPORT-1:0] fdx_f    = in_f[5*NPORT-1:4*NPORT];

   // The rate event counts once per rising edge, so a long pulse is one event.
   logic [NPORT-1:0] rate_prev;
   wire  [NPORT-1:0] rate_event = rate_f & ~rate_prev;

   ////////////////////////////////////////////////////////////////////////////////////////
   // APB decode.

   // One wait state: the access phase captures read data, the next edge completes.
   wire        access    = psel & penable;
   wire        done      = access & pready;
   wire        wr_done   = done & pwrite;
   wire        rd_done   = done & ~pwrite;
   wire [1:0]  area      = paddr[11:10];
   wire [1:0]  port_sel  = paddr[PORT_SEL_LSB+1:PORT_SEL_LSB];
   wire [7:0]  port_ofs  = paddr[7:0];
   wire [7:0]  glob_ofs  = paddr[7:0];
   wire        in_port   = (area == PORT_AREA) & (paddr[1:0] == 2'h0);
   wire        in_glob   = (area == GLOBAL_AREA) & (paddr[9:8] == 2'h0);
   wire        hit_ctrl  = in_port & (port_ofs == {CTRL_IDX[5:0], 2'h0});
   wire        hit_stat  = in_port & (port_ofs == {STAT_IDX[5:0], 2'h0});
   wire        hit_emask = in_port & (port_ofs == {EMASK_IDX[5:0], 2'h0});
   wire        hit_ists  = in_glob & (glob_ofs == IRQ_STATUS_OFS);
   wire        hit_imask = in_glob & (glob_ofs == IRQ_MASK_OFS);
   wire        hit_summ  = in_glob & (glob_ofs == SUMMARY_OFS);
   wire        hit_mauf  = in_glob & (glob_ofs == MAU_FLAG_OFS);
   wire        hit_srst  = in_glob & (glob_ofs == SOFT_RESET_OFS);
   wire        mapped    = hit_ctrl | hit_stat | hit_emask | hit_ists | hit_imask |
                           hit_summ | hit_mauf | hit_srst;

   // Soft reset is a write of one to bit 0 of its command register.
   wire        soft_reset_cmd = wr_done & hit_srst & pwdata[0];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Per-port register sets.

   logic [15:0]      ctrl      [NPORT];
   logic [15:0]      emask     [NPORT];
   logic [NPORT-1:0] rate_err;
   logic [15:0]      stat_word [NPORT];
   logic [NPORT-1:0] any_err;
   logic [NPORT-1:0] reportable;
   logic [NPORT-1:0] hb_inhibit;
   logic [15:0]      rd_capture;

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      wire sel_me   = (port_sel == 2'(p));
      wire wr_ctrl  = wr_done & hit_ctrl & sel_me;
      wire wr_emask = wr_done & hit_emask & sel_me;
      wire rd_stat  = rd_done & hit_stat & sel_me;

      // Reserved bits never store; soft reset spares bits 5 and 2.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctrl[p] <= CTRL_RESET;
         end else if (wr_ctrl) begin
            ctrl[p] <= pwdata[15:0] & CTRL_WMASK;
         end else if (soft_reset_cmd) begin
            ctrl[p] <= (ctrl[p] & CTRL_KEEP_SRST) | (CTRL_RESET & ~CTRL_KEEP_SRST);
         end
      end

      // Error mask enables one error class each.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            emask[p] <= EMASK_RESET;
         end else if (wr_emask) begin
            emask[p] <= pwdata[15:0] & EMASK_WMASK;
         end else if (soft_reset_cmd) begin
            emask[p] <= EMASK_RESET;
         end
      end

      // The read clears only the value it returned, so a later event survives.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rate_err[p] <= 1'b0;
         end else if (soft_reset_cmd) begin
            rate_err[p] <= rate_event[p];
         end else begin
            rate_err[p] <= (rate_err[p] & ~(rd_stat & rd_capture[ST_RATE])) |
                           rate_event[p];
         end
      end

      // Live levels for polarity and jabber; the upper bits are constant zero.
      assign stat_word[p] = {13'h0000, rate_err[p], polrev_f[p], jabber_f[p]};
      assign any_err[p]   = |stat_word[p][2:0];
      assign reportable[p] = |(stat_word[p][2:0] & emask[p][2:0]);
      assign hb_inhibit[p] = ctrl[p][CTRL_HB_OFF] | fdx_f[p];

      heartbeat_check u_hb (
         .pclk      (pclk),
         .presetn   (presetn),
         .tx_active (txact_f[p]),
         .inhibit   (hb_inhibit[p]),
         .collision (muxed_collision_out[p])
      );

      assign force_link_good[p]       = ctrl[p][CTRL_FORCE_LINK];
      assign link_pulse_disable[p]    = ctrl[p][CTRL_NO_LINK_PULSE];
      assign polarity_corr_disable[p] = ctrl[p][CTRL_POL_FIX_OFF];
      assign extended_distance[p]     = ctrl[p][CTRL_EXT_DIST];
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Global flags and interrupt.

   logic [NPORT-1:0] any_err_prev;
   logic [NPORT-1:0] report_prev;
   logic [NPORT-1:0] irq_status;
   logic [NPORT-1:0] irq_mask;
   logic             mau_flag;
   wire  [NPORT-1:0] err_rise    = any_err & ~any_err_prev;
   wire  [NPORT-1:0] report_rise = reportable & ~report_prev;
   wire              rd_mauf     = rd_done & hit_mauf;
   wire              wr_ists     = wr_done & hit_ists;
   wire              wr_imask    = wr_done & hit_imask;
   wire [NPORT-1:0]  w1c         = wr_ists ? pwdata[NPORT-1:0] : '0;
   wire [NPORT-1:0]  next_irq_status = (irq_status & ~w1c) | report_rise;
   wire              next_irq    = |(next_irq_status & irq_mask);

   // Edge history for the event detectors.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_prev    <= '0;
         any_err_prev <= '0;
         report_prev  <= '0;
      end else begin
         rate_prev    <= rate_f;
         any_err_prev <= any_err;
         report_prev  <= reportable;
      end
   end

   // MAU flag is set by any error becoming set; a read clears what it returned.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mau_flag <= 1'b0;
      end else begin
         mau_flag <= (mau_flag & ~(rd_mauf & rd_capture[MAU_FLAG_BIT])) | (|err_rise);
      end
   end

   // Sticky interrupt status, write one to clear; a new event wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq_mask   <= '0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask   <= wr_imask ? pwdata[NPORT-1:0] : irq_mask;
      end
   end

   // The pin form of the interrupt only works when port 0 enables it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq                 <= 1'b0;
         status_change_irq_n <= 1'b1;
      end else begin
         irq                 <= next_irq;
         status_change_irq_n <= ~(next_irq & ctrl[0][CTRL_IRQ_PIN_EN]);
      end
   end

   // Summary bits and the port-0 attachment selection, registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mau_error_summary <= '0;
         aui_select        <= 1'b0;
         aui_special_mode  <= 1'b0;
      end else begin
         mau_error_summary <= reportable;
         aui_select        <= ctrl[0][CTRL_AUI_SEL];
         aui_special_mode  <= ctrl[0][CTRL_AUI_SEL] & ctrl[0][CTRL_IRQ_PIN_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read data and handshake.

   logic [15:0] summary_word;

   // Each port owns four summary bits; only the MAU error position is kept here.
   always_comb begin
      summary_word = 16'h0000;
      for (int p = 0; p < NPORT; p++) begin
         summary_word[p*SUMMARY_STRIDE] = mau_error_summary[p];
      end
   end

   wire [15:0] ctrl_sel  = ctrl[port_sel] & CTRL_WMASK;
   wire [15:0] stat_sel  = stat_word[port_sel];
   wire [15:0] emask_sel = emask[port_sel] & EMASK_WMASK;
   wire [15:0] mauf_word = {14'h0000, mau_flag, 1'b0};
   wire [15:0] irq_word  = {12'h000, irq_status};
   wire [15:0] mask_word = {12'h000, irq_mask};
   wire [15:0] rd_word   = hit_ctrl  ? ctrl_sel  :
                           hit_stat  ? stat_sel  :
                           hit_emask ? emask_sel :
                           hit_ists  ? irq_word  :
                           hit_imask ? mask_word :
                           hit_summ  ? summary_word :
                           hit_mauf  ? mauf_word : 16'h0000;

   // The captured word is what the master sees and what a clear-on-read removes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
         rd_capture <= 16'h0000;
      end else begin
         pready     <= access & ~pready;
         pslverr    <= access & ~pready & ~mapped;
         prdata     <= (access & ~pready & ~pwrite) ? {16'h0000, rd_word} : prdata;
         rd_capture <= (access & ~pready) ? rd_word : rd_capture;
      end
   end

endmodule : port_phy_control_status_regs

// ### sim/port_phy_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Pin-level checks of bus timing, decode, control pins and heartbeat shape.
module port_phy_asserts import port_phy_pkg::*; #(
   parameter int NPORT = 4
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [NPORT-1:0] tx_active,
   input wire logic [NPORT-1:0] full_duplex,
   input wire logic [NPORT-1:0] force_link_good,
   input wire logic             aui_select,
   input wire logic             aui_special_mode,
   input wire logic [NPORT-1:0] muxed_collision_out,
   input wire logic             irq,
   input wire logic             status_change_irq_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Access phase: one wait state, then a single ready pulse.
   sequence wait_state_s;
      psel && penable && !pready;
   endsequence
   sequence ready_pulse_s;
      psel && penable && pready ##1 !pready;
   endsequence
   // The heartbeat stays up for the first eight cycles of its width.
   sequence hb_hold_s;
      muxed_collision_out[0] [*8];
   endsequence

   ready_timing_a: assert property ($rose(penable) && psel |-> wait_state_s ##1 ready_pulse_s)
      else $error("ready not in second access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   unmapped_err_a: assert property (pready && paddr[11] |-> pslverr)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && paddr == 12'h048 |-> !pslverr)
      else $error("control access refused");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   ctrl_rsvd_a: assert property (pready && !pwrite && !paddr[10] && paddr[7:0] == 8'h48
      |-> prdata[14:6] == 9'h000) else $error("reserved control bits not zero");
   force_link_a: assert property (pready && pwrite && paddr == 12'h048
      |=> force_link_good[0] == $past(pwdata[CTRL_FORCE_LINK])) else $error("force pin wrong");
   aui_follow_a: assert property (pready && pwrite && paddr == 12'h048 |-> ##2
      aui_select == $past(pwdata[CTRL_AUI_SEL], 2) && aui_special_mode ==
      $past(pwdata[CTRL_AUI_SEL] && pwdata[CTRL_IRQ_PIN_EN], 2)) else $error("aui pins wrong");
   hb_width_a: assert property ($rose(muxed_collision_out[0]) |->
      hb_hold_s ##12 muxed_collision_out[0] ##1 !muxed_collision_out[0])
      else $error("heartbeat width wrong");
   hb_cause_a: assert property ($rose(muxed_collision_out[0]) |->
      $past(!tx_active[0] && !full_duplex[0], 8)) else $error("heartbeat without cause");
   pin_gated_a: assert property (!status_change_irq_n |-> irq)
      else $error("interrupt pin low without interrupt");
endmodule : port_phy_asserts

bind port_phy_control_status_regs port_phy_asserts #(.NPORT(NPORT)) chk_u (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .tx_active, .full_duplex, .force_link_good, .aui_select, .aui_special_mode,
   .muxed_collision_out, .irq, .status_change_irq_n);

// ### sim/mgmt_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Management controller model: one transfer at a time on the register bus.
module mgmt_master (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Idle bus from time zero so no stray setup is seen.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // Entered just after a rising edge; the answer is taken at the ready edge.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data must not look like a held value.
      @(posedge pclk);
   endtask : xfer
endmodule : mgmt_master

// ### sim/testbench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
   import port_phy_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  rate_mismatch_evt = 4'h0, rx_polarity_reversed = 4'h0, tx_jabber = 4'h0;
   logic [3:0]  tx_active = 4'h0, full_duplex = 4'h0, muxed_collision_out, mau_error_summary;
   logic [3:0]  force_link_good, link_pulse_disable, polarity_corr_disable, extended_distance;
   logic        aui_select, aui_special_mode, irq, status_change_irq_n;
   int          err_total = 0;
   int          checks = 0;

   port_phy_control_status_regs #(.NPORT(4)) dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rate_mismatch_evt,
      .rx_polarity_reversed, .tx_jabber, .tx_active, .full_duplex, .force_link_good,
      .link_pulse_disable, .polarity_corr_disable, .extended_distance, .aui_select,
      .aui_special_mode, .muxed_collision_out, .mau_error_summary, .irq, .status_change_irq_n);
   mgmt_master mst_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);

   // Free-running 20 MHz clock.
   initial forever #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   // Shared compare and bus helpers; a refusal is expected only above 0x7ff.
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      mst_u.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
      logic [31:0] q;
      logic        e;
      mst_u.xfer(1'b0, a, 32'h0, q, e);
      chk(nm, ex, q);
      chk({nm, "_err"}, 32'(a[11]), 32'(e));
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   // Reset values of every port's bank and the pins.
   task automatic t_reset;
      for (int p = 0; p < 4; p++) begin
         rd({2'h0, 2'(p), 8'h48}, 32'h20, "ctrl_rst");
         rd({2'h0, 2'(p), 8'h4c}, 32'h0, "stat_rst");
         rd({2'h0, 2'(p), 8'h50}, 32'h0, "mask_rst");
      end
      @(negedge pclk);
      chk("pins_rst", 32'h1, 32'({force_link_good, aui_select, irq, status_change_irq_n}));
      @(posedge pclk);
   endtask : t_reset

   // All-ones into each control in turn: only that port's pins move.
   task automatic t_ctrl;
      logic [3:0] m;
      for (int p = 0; p < 4; p++) begin
         m = 4'h1 << p;
         wr({2'h0, 2'(p), 8'h48}, 32'hffff_ffff);
         rd({2'h0, 2'(p), 8'h48}, 32'h803f, "ctrl_rw");
         @(negedge pclk);
         chk("ctrl_pins", 32'({m, m, m, m}), 32'({force_link_good, link_pulse_disable,
             polarity_corr_disable, extended_distance}));
         chk("aui_pins", (p == 0) ? 32'h3 : 32'h0, 32'({aui_select, aui_special_mode}));
         @(posedge pclk);
         wr({2'h0, 2'(p), 8'h48}, 32'h20);
      end
   endtask : t_ctrl

   // Sticky versus live status bits, each on its own port.
   task automatic t_status;
      rate_mismatch_evt <= 4'h4;
      rx_polarity_reversed <= 4'h2;
      tx_jabber <= 4'h8;
      idle(8);
      rate_mismatch_evt <= 4'h0;
      rd(12'h24c, 32'h4, "rate");
      rd(12'h24c, 32'h0, "rate_cor");
      rd(12'h04c, 32'h0, "stat_other");
      rd(12'h14c, 32'h2, "pol");
      rd(12'h14c, 32'h2, "pol_kept");
      rd(12'h34c, 32'h1, "jab");
      rx_polarity_reversed <= 4'h0;
      tx_jabber <= 4'h0;
      idle(8);
      wr(12'h14c, 32'hffff);
      rd(12'h14c, 32'h0, "pol_off");
      rd(12'h34c, 32'h0, "jab_off");
      rd(12'h40c, 32'h2, "flag_any");
   endtask : t_status

   // Masked error reaches summary, flag and interrupt; then the pin is disabled and the status cleared.
   task automatic t_irq;
      wr(12'h050, 32'hffff);
      rd(12'h050, 32'h7, "mask_rw");
      rd(12'h40c, 32'h0, "flag_idle");
      tx_jabber <= 4'h1;
      rx_polarity_reversed <= 4'h2;
      idle(8);
      @(negedge pclk);
      chk("summary_pins", 32'h2, 32'({mau_error_summary, irq}));
      @(posedge pclk);
      rd(12'h408, 32'h1, "summary");
      rd(12'h40c, 32'h2, "flag");
      rd(12'h40c, 32'h0, "flag_cor");
      rd(12'h400, 32'h1, "irq_status");
      wr(12'h404, 32'h1);
      @(negedge pclk);
      chk("irq_pin_on", 32'h2, 32'({irq, status_change_irq_n}));
      @(posedge pclk);
      wr(12'h048, 32'h0);
      @(negedge pclk);
      chk("irq_pin_off", 32'h3, 32'({irq, status_change_irq_n}));
      @(posedge pclk);
      tx_jabber <= 4'h0;
      rx_polarity_reversed <= 4'h0;
      idle(8);
      wr(12'h400, 32'h1);
      @(negedge pclk);
      chk("irq_clear", 32'h0, 32'(irq));
      @(posedge pclk);
      wr(12'h048, 32'h20);
   endtask : t_irq

   // One frame on port 0; measures heartbeat delay and width.
   task automatic hb_run(input logic on, input string nm);
      int n;
      int w;
      tx_active <= 4'h1;
      idle(10);
      tx_active <= 4'h0;
      n = 0;
      w = 0;
      while (muxed_collision_out[0] !== 1'b1 && n < 60) begin
         @(negedge pclk);
         n++;
      end
      while (muxed_collision_out[0] === 1'b1 && w < 40) begin
         @(negedge pclk);
         w++;
      end
      @(posedge pclk);
      chk({nm, "_seen"}, 32'(on), 32'(n < 60));
      if (on) chk({nm, "_delay"}, 32'h1, 32'(n >= 20 && n <= 28));
      if (on) chk({nm, "_width"}, 32'h14, 32'(w));
   endtask : hb_run
   task automatic t_heartbeat;
      hb_run(1'b1, "hb");
      wr(12'h048, 32'h21);
      hb_run(1'b0, "hb_off");
      wr(12'h048, 32'h20);
      full_duplex <= 4'h1;
      hb_run(1'b0, "hb_fdx");
      full_duplex <= 4'h0;
   endtask : t_heartbeat

   // Refused address, soft reset exemptions, then a second hardware reset.
   task automatic t_misc;
      wr(12'ha48, 32'hffff);
      rd(12'ha48, 32'h0, "unmapped");
      rd(12'h048, 32'h20, "ctrl_kept");
      wr(12'h048, 32'h803f);
      wr(12'h050, 32'h7);
      wr(12'h410, 32'h1);
      rd(12'h048, 32'h24, "srst_ctrl");
      rd(12'h050, 32'h0, "srst_mask");
      presetn <= 1'b0;
      idle(3);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h048, 32'h20, "hw_reset");
   endtask : t_misc

   ////////////////////////////////////////////////////////////////////////////
   // Verdict; reached from the main sequence or the watchdog.
   task automatic end_of_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // Main sequence after 12 cycles of reset.
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ctrl();
      t_status();
      t_irq();
      t_heartbeat();
      t_misc();
      end_of_test();
   end

   // The whole run needs about 500 cycles; a hang is cut off well beyond.
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      end_of_test();
   end
endmodule : testbench
